// file: src/uasi_pkg.sv
/*
 * Constants for the UART status and interrupt identification block:
 * register byte addresses, field positions, reset values and codes.
 * Assumes a 32-bit Wishbone address space with byte addressing.
 */
`default_nettype none

package uasi_pkg;

    // ****************************************************************
    // Register byte addresses
    // ****************************************************************
    localparam logic [31:0] ADDR_RX_TX      = 32'hFFFF0800;
    localparam logic [31:0] ADDR_IRQ_ENABLE = 32'hFFFF0804;
    localparam logic [31:0] ADDR_IRQ_IDENT  = 32'hFFFF0808;
    localparam logic [31:0] ADDR_LINE_STAT  = 32'hFFFF0814;
    localparam logic [31:0] ADDR_MODEM_STAT = 32'hFFFF0818;
    localparam logic [31:0] ADDR_EVT_STATUS = 32'hFFFF081C;
    localparam logic [31:0] ADDR_EVT_MASK   = 32'hFFFF0820;

    // ****************************************************************
    // Line status fields
    // ****************************************************************
    localparam int LSR_RX_AVAIL  = 0;
    localparam int LSR_OVERRUN   = 1;
    localparam int LSR_PARITY    = 2;
    localparam int LSR_FRAMING   = 3;
    localparam int LSR_BREAK     = 4;
    localparam int LSR_HOLD_EMPT = 5;
    localparam int LSR_TX_IDLE   = 6;
    localparam logic [7:0] LSR_RESET = 8'h60;

    // ****************************************************************
    // Interrupt enable fields and identification codes
    // ****************************************************************
    localparam int IEN_RX_FULL  = 0;
    localparam int IEN_TX_EMPTY = 1;
    localparam int IEN_LINE_ST  = 2;
    localparam logic [7:0] IEN_RESET     = 8'h00;
    localparam logic [7:0] IEN_USED_MASK = 8'h07;
    localparam logic [7:0] IID_RESET     = 8'h01;
    localparam logic [1:0] IID_LINE_ST   = 2'h3;
    localparam logic [1:0] IID_RX_FULL   = 2'h2;
    localparam logic [1:0] IID_TX_EMPTY  = 2'h1;
    localparam logic [1:0] IID_MODEM     = 2'h0;

    // ****************************************************************
    // Sticky event bits (one per interrupt source) and break timing
    // ****************************************************************
    localparam int EVT_MODEM   = 0;
    localparam int EVT_TX      = 1;
    localparam int EVT_RX      = 2;
    localparam int EVT_LINE_ST = 3;
    localparam int EVT_WIDTH   = 4;
    localparam logic [7:0] EVT_RESET      = 8'h00;
    localparam int         MAX_FRAME_BITS = 12;

endpackage : uasi_pkg

`default_nettype wire

// file: src/uasi_top.sv
/*
 * UART line status, interrupt enable and prioritised interrupt
 * identification, behind a classic Wishbone slave.
 * Assumes the rest of the UART supplies receive strobes with error
 * bits, a one-per-bit-time tick, the shift register state and the
 * divisor access select bit; all inputs are synchronous to clk_i.
 */
// The Wishbone slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Transmitter idle flag (bit 6) is set when holding and shift registers are both empty, cleared by a write.
// - Holding empty flag (bit 5) is set once the holding register is empty, cleared by a write to it.
// - Break flag (bit 4) is set when the receive input stays low longer than a longest character frame.
// - Framing error flag (bit 3) is set when a received stop bit is invalid.
// - Parity error flag (bit 2) is set when a received character fails its parity check.
// - Overrun flag (bit 1) is set when a new character overwrites unread receive data.
// - Data available flag (bit 0) is set by a received character and cleared by reading the receive buffer.
// - Line status is read only, bit 7 reads zero, and it resets to transmit flags set, others clear.
// - With enable bit 2 set, a framing, parity or overrun flag requests a line status interrupt.
// - With enable bit 1 set, an empty holding register requests a transmit empty interrupt.
// - With enable bit 0 set, an available character requests an interrupt; enable bits 7 to 3 read zero.
// - Identification bit 0 is an active low pending flag and the register resets to no interrupt.
// - Identification bits 2:1 give the top pending source, each cleared by its own access.
// - With divisor access select clear, the shared offsets reach receive, transmit and enable registers.
module uasi_top #(
    parameter int MAX_FRAME_BITS = uasi_pkg::MAX_FRAME_BITS
) (
    input  wire logic        clk_i,
    input  wire logic        srst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [31:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        divisor_access_select_i,
    input  wire logic        bit_tick_i,
    input  wire logic        serial_rx_input_i,
    input  wire logic        rx_char_i,
    input  wire logic [7:0]  rx_data_i,
    input  wire logic        rx_frame_err_i,
    input  wire logic        rx_parity_err_i,
    input  wire logic        tx_load_i,
    input  wire logic        tx_shift_empty_i,
    input  wire logic        modem_irq_i,
    input  wire logic [7:0]  modem_status_i,
    output logic             tx_write_o,
    output logic      [7:0]  tx_data_o,
    output logic             modem_status_read_o,
    output logic             irq_o
);

    localparam int BW = $clog2(MAX_FRAME_BITS + 2);

    if (MAX_FRAME_BITS < 2 || MAX_FRAME_BITS > 64)
    begin : g_bad_frame
        $error("MAX_FRAME_BITS out of range 2..64");
    end

    // ****************************************************************
    // Bus decode
    // ****************************************************************
    logic acc, rd, wr, shared_sel;
    logic rbr_rd, thr_wr, ien_wr, iid_rd, lsr_rd, msr_rd, evs_wr, evm_wr;

    // A request is served once, in the cycle before ack rises
    assign acc      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign rd       = acc & ~wb_we_i;
    assign wr       = acc & wb_we_i & wb_sel_i[0];
    assign shared_sel = ~divisor_access_select_i;
    assign rbr_rd   = rd & shared_sel & (wb_adr_i == uasi_pkg::ADDR_RX_TX);
    assign thr_wr   = wr & shared_sel & (wb_adr_i == uasi_pkg::ADDR_RX_TX);
    assign ien_wr   = wr & shared_sel & (wb_adr_i == uasi_pkg::ADDR_IRQ_ENABLE);
    assign iid_rd   = rd & (wb_adr_i == uasi_pkg::ADDR_IRQ_IDENT);
    assign lsr_rd   = rd & (wb_adr_i == uasi_pkg::ADDR_LINE_STAT);
    assign msr_rd   = rd & (wb_adr_i == uasi_pkg::ADDR_MODEM_STAT);
    assign evs_wr   = wr & (wb_adr_i == uasi_pkg::ADDR_EVT_STATUS);
    assign evm_wr   = wr & (wb_adr_i == uasi_pkg::ADDR_EVT_MASK);

    // ****************************************************************
    // Receive side flags
    // ****************************************************************
    logic          rx_avail_flag_reg, overrun_flag_reg, parity_error_flag_reg;
    logic          framing_error_flag_reg, break_seen_flag_reg;
    logic [7:0]    rx_buf_reg;
    logic [BW-1:0] brk_cnt_reg;
    logic          brk_hit;

    // Low beyond a full frame: fires once, on the tick that exceeds it
    assign brk_hit = bit_tick_i & ~serial_rx_input_i & (brk_cnt_reg == BW'(MAX_FRAME_BITS));

    // Counter saturates so one long break sets the flag only once
    always_ff @(posedge clk_i)
    begin
        if (srst_i || serial_rx_input_i)
            brk_cnt_reg <= '0;
        else if (bit_tick_i && brk_cnt_reg != BW'(MAX_FRAME_BITS + 1))
            brk_cnt_reg <= brk_cnt_reg + BW'(1);
    end

    // Receive buffer; a new character always overwrites
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            rx_buf_reg <= 8'h00;
        else if (rx_char_i)
            rx_buf_reg <= rx_data_i;
    end

    // Data available: a character arriving with the read wins
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            rx_avail_flag_reg <= 1'b0;
        else if (rx_char_i)
            rx_avail_flag_reg <= 1'b1;
        else if (rbr_rd)
            rx_avail_flag_reg <= 1'b0;
    end

    // Error flags: set wins over the clearing line status read
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            overrun_flag_reg       <= 1'b0;
            parity_error_flag_reg  <= 1'b0;
            framing_error_flag_reg <= 1'b0;
            break_seen_flag_reg    <= 1'b0;
        end
        else
        begin
            overrun_flag_reg       <= (rx_char_i & rx_avail_flag_reg & ~rbr_rd) |
                                      (overrun_flag_reg & ~lsr_rd);
            parity_error_flag_reg  <= (rx_char_i & rx_parity_err_i) |
                                      (parity_error_flag_reg & ~lsr_rd);
            framing_error_flag_reg <= (rx_char_i & rx_frame_err_i) |
                                      (framing_error_flag_reg & ~lsr_rd);
            break_seen_flag_reg    <= brk_hit | (break_seen_flag_reg & ~lsr_rd);
        end
    end

    // ****************************************************************
    // Transmit side flags
    // ****************************************************************
    logic holding_empty_flag_reg, transmitter_idle_flag_reg, tx_irq_reg;

    // A write refills the holding register, so it beats a load
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            holding_empty_flag_reg <= 1'b1;
        else if (thr_wr)
            holding_empty_flag_reg <= 1'b0;
        else if (tx_load_i)
            holding_empty_flag_reg <= 1'b1;
    end

    // Idle only when nothing waits and nothing shifts
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            transmitter_idle_flag_reg <= 1'b1;
        else if (thr_wr)
            transmitter_idle_flag_reg <= 1'b0;
        else
            transmitter_idle_flag_reg <= holding_empty_flag_reg & ~tx_load_i & tx_shift_empty_i;
    end

    // Holding data goes straight to the transmitter
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            tx_write_o <= 1'b0;
            tx_data_o  <= 8'h00;
        end
        else
        begin
            tx_write_o <= thr_wr;
            if (thr_wr)
                tx_data_o <= wb_dat_i[7:0];
        end
    end

    // ****************************************************************
    // Interrupt enable and identification
    // ****************************************************************
    logic [7:0] ien_reg, iid_value, lsr_value;
    logic [1:0] iid_code;
    logic       ls_pend, rx_pend, tx_pend, ms_pend, any_pend;

    // Reserved enable bits are never stored, so they read zero
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            ien_reg <= uasi_pkg::IEN_RESET;
        else if (ien_wr)
            ien_reg <= wb_dat_i[7:0] & uasi_pkg::IEN_USED_MASK;
    end

    // Transmit request re-arms on each load or when freshly enabled
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            tx_irq_reg <= 1'b0;
        else if (tx_load_i || (ien_wr && wb_dat_i[uasi_pkg::IEN_TX_EMPTY] &&
                 !ien_reg[uasi_pkg::IEN_TX_EMPTY] && holding_empty_flag_reg))
            tx_irq_reg <= 1'b1;
        else if (thr_wr || (iid_rd && any_pend && iid_code == uasi_pkg::IID_TX_EMPTY))
            tx_irq_reg <= 1'b0;
    end

    // Sources in falling priority
    assign ls_pend  = ien_reg[uasi_pkg::IEN_LINE_ST] &
                      (framing_error_flag_reg | parity_error_flag_reg | overrun_flag_reg);
    assign rx_pend  = ien_reg[uasi_pkg::IEN_RX_FULL] & rx_avail_flag_reg;
    assign tx_pend  = ien_reg[uasi_pkg::IEN_TX_EMPTY] & tx_irq_reg & holding_empty_flag_reg;
    assign ms_pend  = modem_irq_i;
    assign any_pend = ls_pend | rx_pend | tx_pend | ms_pend;

    // Priority encoder for identification
    always_comb
    begin
        if (ls_pend)
            iid_code = uasi_pkg::IID_LINE_ST;
        else if (rx_pend)
            iid_code = uasi_pkg::IID_RX_FULL;
        else if (tx_pend)
            iid_code = uasi_pkg::IID_TX_EMPTY;
        else
            iid_code = uasi_pkg::IID_MODEM;
    end

    assign iid_value = {5'h00, iid_code & {2{any_pend}}, ~any_pend};
    assign lsr_value = {1'b0, transmitter_idle_flag_reg, holding_empty_flag_reg,
                        break_seen_flag_reg, framing_error_flag_reg, parity_error_flag_reg,
                        overrun_flag_reg, rx_avail_flag_reg};

    // ****************************************************************
    // Sticky event status, mask and interrupt output
    // ****************************************************************
    logic [uasi_pkg::EVT_WIDTH-1:0] pend_vec, pend_prev_reg, evt_stat_reg, evt_mask_reg;

    assign pend_vec = {ls_pend, rx_pend, tx_pend, ms_pend};

    // Remember source levels to find their rising edges
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            pend_prev_reg <= '0;
        else
            pend_prev_reg <= pend_vec;
    end

    // Write one to clear; a new event in the same cycle wins
    for (genvar i = 0; i < uasi_pkg::EVT_WIDTH; i++)
    begin : g_evt
        always_ff @(posedge clk_i)
        begin
            if (srst_i)
                evt_stat_reg[i] <= 1'b0;
            else if (pend_vec[i] && !pend_prev_reg[i])
                evt_stat_reg[i] <= 1'b1;
            else if (evs_wr && wb_dat_i[i])
                evt_stat_reg[i] <= 1'b0;
        end
    end

    // Mask and interrupt level; output one cycle behind the status
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            evt_mask_reg <= '0;
            irq_o        <= 1'b0;
        end
        else
        begin
            if (evm_wr)
                evt_mask_reg <= wb_dat_i[uasi_pkg::EVT_WIDTH-1:0];
            irq_o <= |(evt_stat_reg & evt_mask_reg);
        end
    end

    // ****************************************************************
    // Bus answer
    // ****************************************************************
    // Read data shows state before this access's side effects
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            wb_ack_o            <= 1'b0;
            wb_dat_o            <= 32'h0000_0000;
            modem_status_read_o <= 1'b0;
        end
        else
        begin
            wb_ack_o            <= acc;
            modem_status_read_o <= msr_rd;
            if (rbr_rd)
                wb_dat_o <= {24'h000000, rx_buf_reg};
            else if (rd && shared_sel && wb_adr_i == uasi_pkg::ADDR_IRQ_ENABLE)
                wb_dat_o <= {24'h000000, ien_reg};
            else if (iid_rd)
                wb_dat_o <= {24'h000000, iid_value};
            else if (lsr_rd)
                wb_dat_o <= {24'h000000, lsr_value};
            else if (msr_rd)
                wb_dat_o <= {24'h000000, modem_status_i};
            else if (rd && wb_adr_i == uasi_pkg::ADDR_EVT_STATUS)
                wb_dat_o <= {28'h0000000, evt_stat_reg};
            else if (rd && wb_adr_i == uasi_pkg::ADDR_EVT_MASK)
                wb_dat_o <= {28'h0000000, evt_mask_reg};
            else
                wb_dat_o <= 32'h0000_0000;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);

    property p_thr_clears; thr_wr |=> !holding_empty_flag_reg && !transmitter_idle_flag_reg; endproperty
    a_thr_clears: assert property (p_thr_clears) else $error("write left transmit flags set");
    property p_idle; transmitter_idle_flag_reg |-> holding_empty_flag_reg && $past(tx_shift_empty_i); endproperty
    a_idle: assert property (p_idle) else $error("idle flag without empty transmitter");
    property p_break; brk_hit |=> break_seen_flag_reg; endproperty
    a_break: assert property (p_break) else $error("break not flagged");
    property p_frame; rx_char_i && rx_frame_err_i |=> lsr_value[uasi_pkg::LSR_FRAMING]; endproperty
    a_frame: assert property (p_frame) else $error("framing error lost");
    property p_parity; rx_char_i && rx_parity_err_i |=> lsr_value[uasi_pkg::LSR_PARITY]; endproperty
    a_parity: assert property (p_parity) else $error("parity error lost");
    property p_overrun; rx_char_i && rx_avail_flag_reg && !rbr_rd |=> overrun_flag_reg; endproperty
    a_overrun: assert property (p_overrun) else $error("overrun not flagged");
    property p_rx_read; rbr_rd && !rx_char_i |=> !rx_avail_flag_reg; endproperty
    a_rx_read: assert property (p_rx_read) else $error("data flag not cleared by read");
    property p_lsr_reset; $past(srst_i) |-> lsr_value == uasi_pkg::LSR_RESET && iid_value == uasi_pkg::IID_RESET;
    endproperty
    a_lsr_reset: assert property (p_lsr_reset) else $error("bad reset status");
    property p_ls_id; ls_pend |-> iid_value[2:1] == uasi_pkg::IID_LINE_ST && !iid_value[0]; endproperty
    a_ls_id: assert property (p_ls_id) else $error("line status not reported first");
    property p_tx_id; tx_pend && !ls_pend && !rx_pend |-> iid_value == 8'h02; endproperty
    a_tx_id: assert property (p_tx_id) else $error("transmit empty not reported");
    property p_ien_rsvd; ien_reg[7:3] == 5'h00; endproperty
    a_ien_rsvd: assert property (p_ien_rsvd) else $error("reserved enable bit set");
    property p_no_irq; !any_pend |-> iid_value == uasi_pkg::IID_RESET; endproperty
    a_no_irq: assert property (p_no_irq) else $error("identification without source");
    property p_rx_id; rx_pend && !ls_pend |-> iid_value == 8'h04; endproperty
    a_rx_id: assert property (p_rx_id) else $error("receive full not reported");
    property p_divisor_access_select; divisor_access_select_i && wr |=> $stable(ien_reg) && !tx_write_o; endproperty
    a_divisor_access_select: assert property (p_divisor_access_select) else $error("shared offset reached with divisor access set");
    property p_lsr_clr; lsr_rd && !rx_char_i && !brk_hit |=> lsr_value[4:1] == 4'h0 && !ls_pend; endproperty
    a_lsr_clr: assert property (p_lsr_clr) else $error("line status read did not clear");

endmodule : uasi_top

`default_nettype wire

// file: test/uasi_peer_model.sv
/* Far-side model: the serial line and the UART datapath around the status block.
   Assumes one clock; everything is driven just after its rising edge. */
`timescale 1ns/1ps
`default_nettype none
module uasi_peer_model (
    input  wire logic       clk_i,
    input  wire logic       tx_write_i,
    output logic            bit_tick_o,
    output logic            serial_rx_o,
    output logic            rx_char_o,
    output logic      [7:0] rx_data_o,
    output logic            rx_frame_err_o,
    output logic            rx_parity_err_o,
    output logic            tx_load_o,
    output logic            tx_shift_empty_o
);
    int tx_cnt = 0;
    // Idle line is high (mark); no character in flight
    initial
    begin
        bit_tick_o = 1'b0;
        serial_rx_o = 1'b1;
        rx_char_o = 1'b0;
        rx_data_o = 8'h00;
        rx_frame_err_o = 1'b0;
        rx_parity_err_o = 1'b0;
        tx_load_o = 1'b0;
        tx_shift_empty_o = 1'b1;
    end
    // Transmitter: loads three cycles after a write, then shifts for 42 cycles
    always @(posedge clk_i)
    begin
        tx_cnt <= tx_write_i ? 44 : (tx_cnt > 0 ? tx_cnt - 1 : 0);
        tx_load_o <= (tx_cnt == 42);
        tx_shift_empty_o <= !(tx_cnt > 0 && tx_cnt <= 42);
    end
    // One received character with its error bits
    task automatic send_char(input logic [7:0] d, input logic ferr, input logic perr);
        @(posedge clk_i);
        rx_char_o <= 1'b1;
        rx_data_o <= d;
        rx_frame_err_o <= ferr;
        rx_parity_err_o <= perr;
        @(posedge clk_i);
        rx_char_o <= 1'b0;
        rx_data_o <= ~d;  // Stale byte is not left on the bus
        rx_frame_err_o <= ~ferr;
        rx_parity_err_o <= ~perr;
    endtask : send_char
    // Line held at space for n bit times
    task automatic hold_low(input int n);
        serial_rx_o <= 1'b0;
        repeat (n)
        begin
            @(posedge clk_i);
            bit_tick_o <= 1'b1;
            @(posedge clk_i);
            bit_tick_o <= 1'b0;
        end
    endtask : hold_low
    task automatic release_line();
        @(posedge clk_i);
        serial_rx_o <= 1'b1;
    endtask : release_line
endmodule : uasi_peer_model
`default_nettype wire

// file: test/test_uasi_top.sv
/* Self-checking bench for the status and interrupt identification block.
   Assumes the peer model drives the datapath side; the bench is the bus master. */
`timescale 1ns/1ps
`default_nettype none
module test_uasi_top;
    localparam logic [31:0] RT = uasi_pkg::ADDR_RX_TX;
    localparam logic [31:0] IE = uasi_pkg::ADDR_IRQ_ENABLE;
    localparam logic [31:0] ID = uasi_pkg::ADDR_IRQ_IDENT;
    localparam logic [31:0] LS = uasi_pkg::ADDR_LINE_STAT;
    localparam logic [31:0] ES = uasi_pkg::ADDR_EVT_STATUS;
    localparam logic [31:0] EM = uasi_pkg::ADDR_EVT_MASK;
    logic        clk_i = 1'b0;
    logic        srst_i = 1'b1;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, div_sel = 1'b0, mirq = 1'b0;
    logic [3:0]  sel = 4'h0;
    logic [31:0] adr = 32'h0, wdat = 32'h0, rdat;
    wire logic        ack, tx_wr, mrd, irq, tick, ser, rxc, ferr, perr, load, sempty;
    wire logic [31:0] dat_o;
    wire logic [7:0]  tx_d, rxd;
    int error_cnt = 0;
    int checked = 0;
    int tx_pulses = 0;
    int mrd_pulses = 0;
    always #25 clk_i = ~clk_i;
    uasi_top u_uasi_top (.clk_i(clk_i), .srst_i(srst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .divisor_access_select_i(div_sel), .bit_tick_i(tick), .serial_rx_input_i(ser), .rx_char_i(rxc),
        .rx_data_i(rxd), .rx_frame_err_i(ferr), .rx_parity_err_i(perr), .tx_load_i(load),
        .tx_shift_empty_i(sempty), .modem_irq_i(mirq), .modem_status_i(8'h5A), .tx_write_o(tx_wr),
        .tx_data_o(tx_d), .modem_status_read_o(mrd), .irq_o(irq));
    uasi_peer_model u_uasi_peer_model (.clk_i(clk_i), .tx_write_i(tx_wr), .bit_tick_o(tick),
        .serial_rx_o(ser), .rx_char_o(rxc), .rx_data_o(rxd), .rx_frame_err_o(ferr),
        .rx_parity_err_o(perr), .tx_load_o(load), .tx_shift_empty_o(sempty));
    // Count strobe cycles; a strobe held too long or repeated shows up as extra counts
    always @(posedge clk_i)
    begin
        if (tx_wr === 1'b1)
            tx_pulses <= tx_pulses + 1;
        if (mrd === 1'b1)
            mrd_pulses <= mrd_pulses + 1;
    end
    // ********************************************************************
    // Bus and compare tasks
    // ********************************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Classic cycle: held until the ack edge, read data taken at that edge
    task automatic bus(input logic w, input logic [31:0] a, input logic [7:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'hF;
        wdat <= {24'h0, d};
        @(posedge clk_i);
        while (ack !== 1'b1) @(posedge clk_i);
        rdat = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : bus
    task automatic rd(input logic [31:0] a, input logic [7:0] exp);
        bus(1'b0, a, 8'h00);
        chk(rdat, {24'h0, exp});
    endtask : rd
    task automatic summarize();
        if (error_cnt == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : summarize
    // Watchdog: the whole sequence needs well under 2000 cycles
    initial
    begin
        repeat (20000) @(posedge clk_i);
        error_cnt++;
        summarize();
    end
    // ********************************************************************
    // Test sequence
    // ********************************************************************
    initial
    begin
        repeat (16) @(posedge clk_i);
        srst_i <= 1'b0;
        rd(LS, 8'h60);
        rd(IE, 8'h00);
        rd(ID, 8'h01);
        rd(32'hFFFF0830, 8'h00);
        bus(1'b1, LS, 8'hFF);
        rd(LS, 8'h60);
        bus(1'b1, IE, 8'hFF);
        rd(IE, 8'h07);
        rd(ID, 8'h02);
        rd(ID, 8'h01);
        bus(1'b1, RT, 8'h3C);
        rd(LS, 8'h00);
        chk({24'h0, tx_d}, 32'h3C);
        repeat (10) @(posedge clk_i);
        rd(LS, 8'h20);
        rd(ID, 8'h02);
        rd(ID, 8'h01);
        repeat (45) @(posedge clk_i);
        rd(LS, 8'h60);
        u_uasi_peer_model.send_char(8'hA5, 1'b0, 1'b0);
        rd(LS, 8'h61);
        mirq <= 1'b1;
        rd(ID, 8'h04);
        rd(RT, 8'hA5);
        rd(ID, 8'h00);
        rd(uasi_pkg::ADDR_MODEM_STAT, 8'h5A);
        mirq <= 1'b0;
        u_uasi_peer_model.send_char(8'h11, 1'b0, 1'b0);
        u_uasi_peer_model.send_char(8'h22, 1'b1, 1'b1);
        rd(ID, 8'h06);
        rd(LS, 8'h6F);
        rd(LS, 8'h61);
        rd(ID, 8'h04);
        rd(RT, 8'h22);
        u_uasi_peer_model.hold_low(12);
        rd(LS, 8'h60);
        u_uasi_peer_model.hold_low(1);
        rd(LS, 8'h70);
        u_uasi_peer_model.release_line();
        rd(LS, 8'h60);
        div_sel <= 1'b1;
        bus(1'b1, IE, 8'h00);
        bus(1'b1, RT, 8'h77);
        rd(RT, 8'h00);
        div_sel <= 1'b0;
        rd(IE, 8'h07);
        chk({24'h0, tx_d}, 32'h3C);
        // Sticky event, mask and write-one-to-clear on the interrupt line
        bus(1'b1, ES, 8'h0F);
        bus(1'b1, EM, 8'h04);
        rd(EM, 8'h04);
        chk({31'h0, irq}, 32'h0);
        u_uasi_peer_model.send_char(8'h33, 1'b0, 1'b0);
        repeat (3) @(posedge clk_i);
        chk({31'h0, irq}, 32'h1);
        rd(ES, 8'h04);
        bus(1'b1, EM, 8'h00);
        repeat (2) @(posedge clk_i);
        chk({31'h0, irq}, 32'h0);
        bus(1'b1, EM, 8'h04);
        repeat (2) @(posedge clk_i);
        chk({31'h0, irq}, 32'h1);
        bus(1'b1, ES, 8'h04);
        repeat (2) @(posedge clk_i);
        chk({31'h0, irq}, 32'h0);
        rd(ES, 8'h00);
        chk(tx_pulses, 32'h1);
        chk(mrd_pulses, 32'h1);
        summarize();
    end
endmodule : test_uasi_top
`default_nettype wire
